// ---- design/shp_pkg.sv ----
// Function
// RQ1: Ordinary bursts allow up to 8 word beats, or 16 half-word beats.
// RQ2: Host holds select or read strobe high between ordinary bursts.
// RQ3: Half-width bursts leave the upper data lanes undriven.
// RQ4: Read cycle starts with select and read strobe low, ends when either rises.
// RQ5: FIFO select high on a read skips decode and reads the receive FIFO.
// RQ6: Direct FIFO reads still use address bits 2..1, ignore bits 7..3. Here bit 1 picks the half and a change of any address bit starts a new beat.
// RQ7: Direct receive FIFO bursts have no beat limit.
// RQ8: After a direct burst ends, host keeps the strobe high before the next.
// RQ9: FIFO select high on a write skips decode and writes the transmit FIFO.
// RQ10: FIFO select is sampled like an address line; cycles are otherwise ordinary.
// RQ11: Direct FIFO writes use address bits 2..1 and ignore bits 7..3.
// RQ12: Writes are single cycles separated by a strobe high period.
// RQ13: Write cycle starts with select and write strobe low, ends when either rises.
// RQ14: Half-width writes ignore the upper data lanes.
// RQ15: Half-width direct single reads leave the upper data lanes undriven.
// RQ16: Data bus is 32 bits with an optional 16-bit width.
// RQ17: Register values are latched once at the start of each read beat.
// RQ18: With FIFO select low the full address is decoded normally.
package shp_pkg;

	localparam int DATA_W      = 32;
	localparam int HALF_W      = 16;
	localparam int FIFO_DEPTH  = 32;
	localparam int BEAT_W      = 5;
	localparam int ADDR_HI     = 7;
	localparam int ADDR_LO     = 1;
	localparam int REGION_HI   = 7;
	localparam int REGION_LO   = 5;
	localparam int HALF_BIT    = 1;

	localparam logic [BEAT_W-1:0] BURST32_MAX = 5'h08;
	localparam logic [BEAT_W-1:0] BURST16_MAX = 5'h10;
	localparam logic [BEAT_W-1:0] BEAT_ZERO   = 5'h00;
	localparam logic [BEAT_W-1:0] BEAT_ONE    = 5'h01;

	localparam logic [2:0]        REGION_RX   = 3'h0;
	localparam logic [2:0]        REGION_TX   = 3'h1;
	localparam logic [DATA_W-1:0] WORD_ZERO   = 32'h00000000;
	localparam logic [HALF_W-1:0] HALF_ZERO   = 16'h0000;

	typedef enum logic [1:0] {
		SHP_IDLE  = 2'h0,
		SHP_READ  = 2'h1,
		SHP_WRITE = 2'h2
	} shp_state_t;

	typedef enum logic [1:0] {
		SHP_TGT_REG = 2'h0,
		SHP_TGT_RX  = 2'h1,
		SHP_TGT_TX  = 2'h2
	} shp_target_t;

	// FIFO select overrides the region bits; bits 2..1 are never part of the decode
	function automatic shp_target_t shp_decode(
		input logic                 fifo_sel,
		input logic [ADDR_HI:ADDR_LO] addr,
		input logic                 is_write
	);
		shp_target_t t;
		t = SHP_TGT_REG;
		if (fifo_sel) begin
			t = is_write ? SHP_TGT_TX : SHP_TGT_RX;
		end else if (!is_write && addr[REGION_HI:REGION_LO] == REGION_RX) begin
			t = SHP_TGT_RX;
		end else if (is_write && addr[REGION_HI:REGION_LO] == REGION_TX) begin
			t = SHP_TGT_TX;
		end
		return t;
	endfunction

	// Clears the upper lanes when the bus is strapped half width
	function automatic logic [DATA_W-1:0] shp_lane_mask(
		input logic [DATA_W-1:0] w,
		input logic              half
	);
		return half ? {HALF_ZERO, w[HALF_W-1:0]} : w;
	endfunction

endpackage

// ---- design/shp_stream_if.sv ----
`timescale 1ns/1ps
interface shp_stream_if #(
	parameter int W = 32
) ();
	logic [W-1:0] data;
	logic         valid;
	logic         ready;

	modport src (
		output data,
		output valid,
		input  ready
	);
	modport snk (
		input  data,
		input  valid,
		output ready
	);
endinterface

// ---- design/shp_fifo.sv ----
`timescale 1ns/1ps
module shp_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 32
) (
	input  wire logic   sys_clk,
	input  wire logic   rstn,
	shp_stream_if.snk   in_s,
	shp_stream_if.src   out_s
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [PW:0]  wr_ptr_r;
	logic [PW:0]  rd_ptr_r;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	// Extra pointer bit tells full from empty without a counter
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full  = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
	assign push  = in_s.valid && !full;
	assign pop   = out_s.ready && !empty;

	assign in_s.ready  = !full;
	assign out_s.valid = !empty;
	assign out_s.data  = mem_r[rd_ptr_r[PW-1:0]];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_ptr_r[PW-1:0]] <= in_s.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wr_ptr_r <= '0;
		end else if (push) begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rd_ptr_r <= '0;
		end else if (pop) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

// ---- design/shp_host_port.sv ----
`timescale 1ns/1ps
module shp_host_port #(
	parameter int DATA_W     = shp_pkg::DATA_W,
	parameter int FIFO_DEPTH = shp_pkg::FIFO_DEPTH
) (
	input  wire logic                          sys_clk,
	input  wire logic                          rstn,
	input  wire logic                          bus_is_16,
	input  wire logic                          chip_select_low,
	input  wire logic                          read_strobe_low,
	input  wire logic                          write_strobe_low,
	input  wire logic                          fifo_sel,
	input  wire logic [shp_pkg::ADDR_HI:shp_pkg::ADDR_LO] addr,
	input  wire logic [DATA_W-1:0]             data_in,
	output logic      [DATA_W-1:0]             data_out,
	output logic                               data_oe_lo,
	output logic                               data_oe_hi,
	output logic [shp_pkg::ADDR_HI:shp_pkg::ADDR_LO] reg_addr,
	output logic                               reg_rd_req,
	input  wire logic [DATA_W-1:0]             reg_rd_data,
	output logic                               reg_wr_stb,
	output logic      [DATA_W-1:0]             reg_wr_data,
	input  wire logic [DATA_W-1:0]             rx_in_data,
	input  wire logic                          rx_in_valid,
	output logic                               rx_in_ready,
	output logic      [DATA_W-1:0]             tx_out_data,
	output logic                               tx_out_valid,
	input  wire logic                          tx_out_ready,
	output logic                               rx_underrun,
	output logic                               tx_overflow,
	output logic                               burst_excess
);

	// ==========================================================
	// FIFOs on the data path
	// ==========================================================
	shp_stream_if #(.W(DATA_W)) rx_in_s  ();
	shp_stream_if #(.W(DATA_W)) rx_out_s ();
	shp_stream_if #(.W(DATA_W)) tx_in_s  ();
	shp_stream_if #(.W(DATA_W)) tx_out_s ();

	assign rx_in_s.data   = rx_in_data;
	assign rx_in_s.valid  = rx_in_valid;
	assign rx_in_ready    = rx_in_s.ready;
	assign tx_out_data    = tx_out_s.data;
	assign tx_out_valid   = tx_out_s.valid;
	assign tx_out_s.ready = tx_out_ready;

	shp_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.in_s    (rx_in_s.snk),
		.out_s   (rx_out_s.src)
	);

	shp_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.in_s    (tx_in_s.snk),
		.out_s   (tx_out_s.src)
	);

	// ==========================================================
	// Cycle framing
	// ==========================================================
	shp_pkg::shp_state_t  state_r;
	shp_pkg::shp_state_t  state_nxt;
	shp_pkg::shp_target_t tgt_r;
	shp_pkg::shp_target_t beat_tgt;
	shp_pkg::shp_target_t wr_tgt;

	logic                                         rd_go;
	logic                                         wr_go;
	logic                                         beat_start;
	logic                                         wr_end;
	logic                                         beat_r;
	logic                                         sel_r;
	logic [shp_pkg::ADDR_HI:shp_pkg::ADDR_LO]     addr_r;
	logic [shp_pkg::BEAT_W-1:0]                   beat_cnt_r;
	logic [shp_pkg::BEAT_W-1:0]                   beat_max;
	logic [DATA_W-1:0]                            wdata_r;
	logic [shp_pkg::HALF_W-1:0]                   tx_lo_r;
	logic [DATA_W-1:0]                            rd_word;
	logic                                         half_hi;
	logic                                         rx_pop;
	logic                                         tx_push;
	logic [DATA_W-1:0]                            data_out_r;
	logic                                         rx_underrun_r;
	logic                                         tx_overflow_r;
	logic                                         burst_excess_r;
	logic                                         reg_rd_req_r;
	logic                                         reg_wr_stb_r;
	logic [DATA_W-1:0]                            reg_wr_data_r;

	// Both strobes low is the only way in; either rising ends the cycle
	assign rd_go = !chip_select_low && !read_strobe_low;   // [RQ4]
	assign wr_go = !chip_select_low && !write_strobe_low;  // [RQ13]

	// Inside a read, a new address marks the next burst beat
	assign beat_start = rd_go && ((state_r == shp_pkg::SHP_IDLE)
		|| (state_r == shp_pkg::SHP_READ && ({fifo_sel, addr} != {sel_r, addr_r})));

	assign wr_end = (state_r == shp_pkg::SHP_WRITE) && !wr_go;  // [RQ13] [RQ12]

	// Same sampling as the address lines, so fifo_sel is just one more bit
	assign beat_tgt = shp_pkg::shp_decode(fifo_sel, addr, 1'b0);  // [RQ5] [RQ10] [RQ18]
	assign wr_tgt   = shp_pkg::shp_decode(sel_r, addr_r, 1'b1);   // [RQ9] [RQ10] [RQ18]

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			shp_pkg::SHP_IDLE: begin
				if (rd_go) begin
					state_nxt = shp_pkg::SHP_READ;
				end else if (wr_go) begin
					state_nxt = shp_pkg::SHP_WRITE;
				end
			end
			shp_pkg::SHP_READ: begin
				if (!rd_go) begin
					state_nxt = shp_pkg::SHP_IDLE;  // [RQ4]
				end
			end
			shp_pkg::SHP_WRITE: begin
				if (!wr_go) begin
					state_nxt = shp_pkg::SHP_IDLE;  // [RQ13]
				end
			end
			default: begin
				state_nxt = shp_pkg::SHP_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_r <= shp_pkg::SHP_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Address and select are held for the whole beat; hold time may be zero
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			addr_r <= '0;
			sel_r  <= 1'b0;
			tgt_r  <= shp_pkg::SHP_TGT_REG;
		end else if (beat_start) begin
			addr_r <= addr;
			sel_r  <= fifo_sel;
			tgt_r  <= beat_tgt;
		end else if (state_r != shp_pkg::SHP_READ && wr_go) begin
			addr_r <= addr;
			sel_r  <= fifo_sel;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			beat_r <= 1'b0;
		end else begin
			beat_r <= beat_start;
		end
	end

	// ==========================================================
	// Burst length policing
	// ==========================================================
	assign beat_max = bus_is_16 ? shp_pkg::BURST16_MAX : shp_pkg::BURST32_MAX;  // [RQ1]

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			beat_cnt_r <= shp_pkg::BEAT_ZERO;
		end else if (beat_start && state_r == shp_pkg::SHP_IDLE) begin
			beat_cnt_r <= shp_pkg::BEAT_ONE;
		end else if (beat_start && beat_cnt_r != beat_max) begin
			beat_cnt_r <= beat_cnt_r + shp_pkg::BEAT_ONE;
		end
	end

	// Only flagged, never refused: the host owns the limit and the data still flows.
	// Direct receive bursts are exempt and may run without bound.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			burst_excess_r <= 1'b0;
		end else if (beat_start && state_r == shp_pkg::SHP_IDLE) begin
			burst_excess_r <= 1'b0;
		end else if (beat_start && !fifo_sel && beat_cnt_r == beat_max) begin
			burst_excess_r <= 1'b1;  // [RQ1] [RQ7]
		end
	end

	// ==========================================================
	// Read data path
	// ==========================================================
	// Bit 1 alone still picks the half in direct mode; bits 7..2 there only mark a new beat when they change
	assign half_hi = addr_r[shp_pkg::HALF_BIT];  // [RQ6]

	// A word leaves the receive FIFO on its last half, or whole on a wide bus
	assign rx_pop = beat_r && (tgt_r == shp_pkg::SHP_TGT_RX)
		&& (!bus_is_16 || half_hi);  // [RQ5] [RQ6]
	assign rx_out_s.ready = rx_pop;

	always_comb begin
		rd_word = reg_rd_data;
		if (tgt_r == shp_pkg::SHP_TGT_RX) begin
			rd_word = rx_out_s.data;
			if (bus_is_16 && half_hi) begin
				rd_word = {shp_pkg::HALF_ZERO, rx_out_s.data[DATA_W-1:shp_pkg::HALF_W]};
			end
		end
	end

	// Latched once per beat, so a counter ticking mid-cycle cannot tear the value
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			data_out_r <= shp_pkg::WORD_ZERO;
		end else if (beat_r) begin
			data_out_r <= shp_pkg::shp_lane_mask(rd_word, bus_is_16);  // [RQ17] [RQ16]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			reg_rd_req_r <= 1'b0;
		end else begin
			reg_rd_req_r <= beat_start && (beat_tgt == shp_pkg::SHP_TGT_REG);  // [RQ18]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rx_underrun_r <= 1'b0;
		end else begin
			rx_underrun_r <= rx_pop && !rx_out_s.valid;
		end
	end

	// Drivers follow the strobes directly so the bus is released at once
	assign data_oe_lo = (state_r == shp_pkg::SHP_READ) && rd_go && !beat_r;  // [RQ4]
	assign data_oe_hi = data_oe_lo && !bus_is_16;  // [RQ3] [RQ15] [RQ16]
	assign data_out   = data_out_r;

	// ==========================================================
	// Write data path
	// ==========================================================
	// Data is only good near the rising strobe, so keep the last sample
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wdata_r <= shp_pkg::WORD_ZERO;
		end else if (wr_go && state_r != shp_pkg::SHP_READ) begin
			wdata_r <= shp_pkg::shp_lane_mask(data_in, bus_is_16);  // [RQ14]
		end
	end

	// Half-width pushes pair low half first, then high half completes the word
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tx_lo_r <= shp_pkg::HALF_ZERO;
		end else if (wr_end && wr_tgt == shp_pkg::SHP_TGT_TX && !addr_r[shp_pkg::HALF_BIT]) begin
			tx_lo_r <= wdata_r[shp_pkg::HALF_W-1:0];  // [RQ11]
		end
	end

	assign tx_push = wr_end && (wr_tgt == shp_pkg::SHP_TGT_TX)
		&& (!bus_is_16 || addr_r[shp_pkg::HALF_BIT]);  // [RQ9] [RQ11]
	assign tx_in_s.valid = tx_push;
	assign tx_in_s.data  = bus_is_16
		? {wdata_r[shp_pkg::HALF_W-1:0], tx_lo_r}
		: wdata_r;

	// A full FIFO drops the word; the host is expected to watch the level
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tx_overflow_r <= 1'b0;
		end else begin
			tx_overflow_r <= tx_push && !tx_in_s.ready;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			reg_wr_stb_r  <= 1'b0;
			reg_wr_data_r <= shp_pkg::WORD_ZERO;
		end else begin
			reg_wr_stb_r  <= wr_end && (wr_tgt == shp_pkg::SHP_TGT_REG);  // [RQ12] [RQ18]
			reg_wr_data_r <= wdata_r;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign reg_addr     = addr_r;
	assign reg_rd_req   = reg_rd_req_r;
	assign reg_wr_stb   = reg_wr_stb_r;
	assign reg_wr_data  = reg_wr_data_r;
	assign rx_underrun  = rx_underrun_r;
	assign tx_overflow  = tx_overflow_r;
	assign burst_excess = burst_excess_r;

endmodule

// ---- tb/shp_host_port_chk.sv ----
`timescale 1ns/1ps
// ==========
// Bus cycle checks on the host port pins
module shp_host_port_chk #(
	parameter int DATA_W = 32
) (
	input wire logic              sys_clk,
	input wire logic              rstn,
	input wire logic              bus_is_16,
	input wire logic              chip_select_low,
	input wire logic              read_strobe_low,
	input wire logic              write_strobe_low,
	input wire logic              fifo_sel,
	input wire logic [7:1]        addr,
	input wire logic              data_oe_lo,
	input wire logic              data_oe_hi,
	input wire logic              reg_rd_req,
	input wire logic              reg_wr_stb,
	input wire logic [DATA_W-1:0] reg_wr_data,
	input wire logic              tx_out_valid,
	input wire logic              burst_excess
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic rd_on;
	logic wr_on;
	logic reg_hit;
	assign rd_on = !chip_select_low && !read_strobe_low;
	assign wr_on = !chip_select_low && !write_strobe_low;
	assign reg_hit = !fifo_sel && addr[7:5] > 3'h1;
	sequence rd_start;
		!rd_on ##1 rd_on;
	endsequence
	sequence wr_end;
		wr_on ##1 !wr_on;
	endsequence
	// A beat counts as settled once its address has stood two edges inside the read
	sequence beat_settled;
		rd_on ##1 (rd_on && $stable({fifo_sel, addr})) [*2];
	endsequence
	half_upper_off_a: assert property (bus_is_16 |-> !data_oe_hi)
		else $error("upper lanes driven in half width");
	drive_window_a: assert property (data_oe_lo |-> rd_on)
		else $error("data driven outside a read");
	read_answer_a: assert property (beat_settled |-> data_oe_lo)
		else $error("read not answered");
	full_width_a: assert property (beat_settled ##0 !bus_is_16 |-> data_oe_hi)
		else $error("upper lanes idle in full width");
	reg_read_req_a: assert property (rd_start ##0 reg_hit |-> ##[1:2] reg_rd_req)
		else $error("register read not requested");
	fifo_read_noreg_a: assert property (rd_start ##0 fifo_sel |=> !reg_rd_req [*3])
		else $error("register read during direct read");
	reg_write_a: assert property (wr_end ##0 reg_hit |-> ##[1:2] reg_wr_stb)
		else $error("register write lost");
	fifo_write_a: assert property (wr_end ##0 fifo_sel |=> !reg_wr_stb [*2])
		else $error("register write during direct write");
	stb_cause_a: assert property (reg_wr_stb |-> $past(wr_on, 2) || $past(wr_on, 3))
		else $error("write strobe without a write");
	half_write_a: assert property (reg_wr_stb && bus_is_16
		|-> reg_wr_data[DATA_W-1:16] == 16'h0000)
		else $error("upper half written in half width");
	tx_push_a: assert property (wr_end ##0 (fifo_sel && (!bus_is_16 || addr[1]))
		|-> ##[1:2] tx_out_valid)
		else $error("direct write not pushed");
	excess_clear_a: assert property (rd_start |-> ##[1:2] !burst_excess)
		else $error("burst flag not cleared");
endmodule

bind shp_host_port shp_host_port_chk #(.DATA_W(DATA_W)) shp_host_port_chk_inst (
	.sys_clk, .rstn, .bus_is_16, .chip_select_low, .read_strobe_low, .write_strobe_low,
	.fifo_sel, .addr, .data_oe_lo, .data_oe_hi, .reg_rd_req, .reg_wr_stb, .reg_wr_data,
	.tx_out_valid, .burst_excess);

// ---- tb/shp_host_model.sv ----
`timescale 1ns/1ps
// ==========
// Host processor side; tasks are entered at a falling edge
module shp_host_model (
	input  wire logic        sys_clk,
	output logic             chip_select_low,
	output logic             read_strobe_low,
	output logic             write_strobe_low,
	output logic             fifo_sel,
	output logic [7:1]       addr,
	output logic [31:0]      data_in,
	input  wire logic [31:0] data_out,
	input  wire logic        data_oe_lo,
	input  wire logic        data_oe_hi
);
	initial begin
		{chip_select_low, read_strobe_low, write_strobe_low} = 3'h7;
		fifo_sel = 1'h0;
		addr = 7'h00;
		data_in = 32'h00000000;
	end
	// A new address inside a read is a new beat; held 3 cycles
	task automatic beat(input logic fs, input logic [7:1] a, output logic [31:0] q);
		fifo_sel = fs;
		addr = a;
		chip_select_low = 1'h0;
		read_strobe_low = 1'h0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		// Undriven lanes read as zero here
		q = {data_oe_hi ? data_out[31:16] : 16'h0000, data_oe_lo ? data_out[15:0] : 16'h0000};
	endtask
	// Strobes high two cycles; released lines flip so stale values never match
	task automatic idle();
		{chip_select_low, read_strobe_low, write_strobe_low} = 3'h7;
		fifo_sel = ~fifo_sel;
		addr = ~addr;
		data_in = ~data_in;
		repeat (2) @(negedge sys_clk);
	endtask
	// Address held past the edge that sees the strobe rise
	task automatic write(input logic fs, input logic [7:1] a, input logic [31:0] d);
		fifo_sel = fs;
		addr = a;
		data_in = d;
		chip_select_low = 1'h0;
		write_strobe_low = 1'h0;
		repeat (2) @(negedge sys_clk);
		write_strobe_low = 1'h1;
		@(negedge sys_clk);
		idle();
	endtask
endmodule

// ---- tb/shp_host_port_tb_top.sv ----
`timescale 1ns/1ps
// ==========
// Bench for the host port
module shp_host_port_tb_top;
	typedef struct packed {
		logic        wr;
		logic        fs;
		logic [7:1]  a;
		logic [31:0] d;
	} shp_row_t;
	logic        sys_clk = 1'h0;
	logic        rstn = 1'h0;
	logic        bus_is_16 = 1'h0;
	logic        chip_select_low, read_strobe_low, write_strobe_low, fifo_sel;
	logic [7:1]  addr, reg_addr;
	logic [31:0] data_in, data_out, reg_rd_data, reg_wr_data, tx_out_data, q;
	logic        data_oe_lo, data_oe_hi, reg_rd_req, reg_wr_stb, rx_in_ready, tx_out_valid;
	logic [31:0] rx_in_data = 32'h00000000;
	logic        rx_in_valid = 1'h0;
	logic        tx_out_ready = 1'h0;
	logic        rx_underrun, tx_overflow, burst_excess;
	logic [31:0] tx_q[$];
	int          err_total = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          wr_cnt = 0;
	int          urun = 0;
	int          oflow = 0;
	int          rx_pushed;
	shp_row_t    rows[6] = '{'{1'h0, 1'h0, 7'h41, 32'hA5000041},
		'{1'h0, 1'h1, 7'h7E, 32'h5A000000}, '{1'h0, 1'h0, 7'h06, 32'h5A000001},
		'{1'h1, 1'h0, 7'h60, 32'h12345678}, '{1'h1, 1'h1, 7'h5C, 32'h0BADF00D},
		'{1'h1, 1'h0, 7'h22, 32'hCAFE0001}};
	logic [7:1]  ha[4] = '{7'h00, 7'h79, 7'h7C, 7'h03};
	logic [15:0] he[4] = '{16'h0000, 16'h5A00, 16'h0001, 16'h5A00};

	shp_host_port shp_host_port_inst (.sys_clk, .rstn, .bus_is_16, .chip_select_low,
		.read_strobe_low, .write_strobe_low, .fifo_sel, .addr, .data_in, .data_out,
		.data_oe_lo, .data_oe_hi, .reg_addr, .reg_rd_req, .reg_rd_data, .reg_wr_stb,
		.reg_wr_data, .rx_in_data, .rx_in_valid, .rx_in_ready, .tx_out_data, .tx_out_valid,
		.tx_out_ready, .rx_underrun, .tx_overflow, .burst_excess);
	shp_host_model shp_host_model_inst (.sys_clk, .chip_select_low, .read_strobe_low,
		.write_strobe_low, .fifo_sel, .addr, .data_in, .data_out, .data_oe_lo, .data_oe_hi);

	always #20 sys_clk = ~sys_clk;
	assign reg_rd_data = 32'hA5000000 | {25'h0000000, reg_addr};

	always @(posedge sys_clk) begin
		cycles++;
		if (reg_wr_stb === 1'h1) wr_cnt++;
		if (rx_underrun === 1'h1) urun++;
		if (tx_overflow === 1'h1) oflow++;
		if (cycles == 8000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic do_reset(input logic half);
		rstn = 1'h0;
		bus_is_16 = half;
		repeat (4) @(negedge sys_clk);
		rstn = 1'h1;
		@(negedge sys_clk);
	endtask

	task automatic rx_fill(input int lim);
		rx_pushed = 0;
		while (rx_in_ready === 1'h1 && rx_pushed < lim) begin
			rx_in_data = 32'h5A000000 + 32'(rx_pushed);
			rx_in_valid = 1'h1;
			@(negedge sys_clk);
			rx_pushed++;
		end
		rx_in_valid = 1'h0;
	endtask

	task automatic reg_burst(input int beats);
		logic [31:0] e;
		for (int i = 0; i < beats; i++) begin
			shp_host_model_inst.beat(1'h0, 7'h40 + 7'(2 * i), q);
			e = 32'hA5000040 + 32'(2 * i);
			if (bus_is_16) e[31:16] = 16'h0000;
			chk(q, e);
		end
		shp_host_model_inst.idle();
	endtask

	// One beat past the limit raises the flag, exactly the limit does not
	task automatic burst_limits();
		for (int k = 0; k < 2; k++) begin
			reg_burst((bus_is_16 ? 16 : 8) + 1 - k);
			chk({31'h0, burst_excess}, 32'(1 - k));
		end
	endtask

	initial begin
		do_reset(1'h0);
		rx_fill(40);
		chk(32'(rx_pushed), 32'h00000020); // RX buffer refuses at its depth
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				shp_host_model_inst.write(rows[i].fs, rows[i].a, rows[i].d);
				if (!rows[i].fs && rows[i].a[7:5] != 3'h1) chk(reg_wr_data, rows[i].d);
				else tx_q.push_back(rows[i].d);
			end else begin
				shp_host_model_inst.beat(rows[i].fs, rows[i].a, q);
				shp_host_model_inst.idle();
				chk(q, rows[i].d);
			end
		end
		chk(32'(wr_cnt), 32'h00000002);
		// Direct burst drains the rest, one beat beyond empty
		for (int i = 0; i < 31; i++) begin
			shp_host_model_inst.beat(1'h1, 7'(2 * i), q);
			if (i < 30) chk(q, 32'h5A000002 + 32'(i));
		end
		shp_host_model_inst.idle();
		chk({31'h0, burst_excess}, 32'h00000000);
		chk(32'(urun), 32'h00000001); // empty pop flagged
		burst_limits();
		// One word already waits, so the 32nd write finds the buffer full
		for (int i = 0; i < 32; i++) begin
			shp_host_model_inst.write(1'h1, 7'(i), 32'hC0000000 + 32'(i));
			if (i < 31) tx_q.push_back(32'hC0000000 + 32'(i));
		end
		chk(32'(oflow), 32'h00000001); // full TX buffer drops the word
		// Drain with the far side stalling every other cycle
		repeat (32) begin
			chk(tx_out_data, tx_q.pop_front());
			tx_out_ready = 1'h1;
			@(negedge sys_clk);
			tx_out_ready = 1'h0;
			@(negedge sys_clk);
		end
		chk({31'h0, tx_out_valid}, 32'h00000000); // TX buffer empty
		do_reset(1'h1);
		chk(data_out, 32'h00000000); // reset clears the read latch
		chk({28'h0000000, rx_in_ready, tx_out_valid, data_oe_lo, data_oe_hi}, 32'h00000008); // reset
		rx_fill(2);
		for (int i = 0; i < 4; i++) begin
			shp_host_model_inst.beat(1'h1, ha[i], q);
			chk(q, {16'h0000, he[i]});
		end
		shp_host_model_inst.idle();
		shp_host_model_inst.write(1'h1, 7'h78, 32'hDEAD1111);
		shp_host_model_inst.write(1'h1, 7'h7B, 32'hBEEF2222);
		chk(tx_out_data, 32'h22221111);
		shp_host_model_inst.write(1'h0, 7'h60, 32'hFFFF3333);
		chk(reg_wr_data, 32'h00003333);
		burst_limits();
		print_verdict();
	end
endmodule
